/* File: rtl/sblh_lsu.v */
// load-store pipeline control: store buffer, load hazard, circular split
// Operation
// - exactly one store buffer entry holds a deferred store
// - a store followed by a load goes into the store buffer
// - buffered store drains on a further store or an idle pipeline
// - dependent load cancelled, store done next cycle, load reissued same size
// - conflict if buffered store hits a half-word of wrapping first access that lies within its 8-byte line
// - circular effective address is buffer base plus index
// - wrapping half-aligned double load splits into 3 halves then 1 wrapped
`include "sblh_consts.vh"
module sblh_lsu (
  // clock and reset
  input  wire                  core_clk,
  input  wire                  arst_n,
  // pipeline request
  input  wire                  req_valid,
  output wire                  req_ready,
  input  wire                  req_store,
  input  wire                  req_circ,
  input  wire [`SBLH_AW-1:0]   req_addr,
  input  wire [`SBLH_AW-1:0]   req_base,
  input  wire [15:0]           req_index,
  input  wire [15:0]           req_length,
  input  wire [1:0]            req_size,
  input  wire [`SBLH_DW-1:0]   req_wdata,
  input  wire [7:0]            req_be,
  // load result
  output reg                   rsp_valid_ff,
  output reg  [`SBLH_DW-1:0]   rsp_data_ff,
  // scratchpad port
  output reg                   mem_req,
  output reg                   mem_we,
  output reg  [`SBLH_AW-1:0]   mem_addr,
  output reg  [2:0]            mem_size,
  output reg  [`SBLH_DW-1:0]   mem_wdata,
  output reg  [7:0]            mem_be,
  input  wire [`SBLH_DW-1:0]   mem_rdata
);
  // ------------------------------------------------------------
  // store buffer entry
  // ------------------------------------------------------------
  wire                sb_valid;
  wire [`SBLH_AW-1:0] sb_addr;
  wire [`SBLH_DW-1:0] sb_data;
  wire [7:0]          sb_be;
  reg                 sb_load;
  reg                 sb_clear;

  reg  [1:0]          state_ff;
  reg  [1:0]          nxt_state;
  reg  [`SBLH_AW-1:0] ld_addr_ff;
  reg  [2:0]          ld_size_ff;
  reg                 ld_wrap_ff;
  reg  [`SBLH_AW-1:0] wrap_addr_ff;
  reg  [`SBLH_AW-1:0] nxt_ld_addr;
  reg  [2:0]          nxt_ld_size;
  reg                 nxt_ld_wrap;
  reg  [`SBLH_AW-1:0] nxt_wrap_addr;
  reg  [1:0]          rd_phase_ff;
  reg  [1:0]          nxt_rd_phase;
  reg  [`SBLH_DW-1:0] part_ff;
  reg                 hold_store_ff;
  reg  [`SBLH_AW-1:0] hs_addr_ff;
  reg  [`SBLH_DW-1:0] hs_data_ff;
  reg  [7:0]          hs_be_ff;

  sblh_entry u_entry (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .load     (sb_load),
    .clear    (sb_clear),
    .addr_in  (hs_addr_ff),
    .data_in  (hs_data_ff),
    .be_in    (hs_be_ff),
    .valid_ff (sb_valid),
    .addr_ff  (sb_addr),
    .data_ff  (sb_data),
    .be_ff    (sb_be)
  );

  // ------------------------------------------------------------
  // address forming and wrap detection
  // ------------------------------------------------------------
  // effective address: base plus index in circular mode
  wire [`SBLH_AW-1:0] eff_addr = req_circ ? (req_base + {16'h0000, req_index})
                                          : req_addr;
  wire [16:0] idx_end  = {1'b0, req_index} + `SBLH_DBL_BYTES;
  wire        half_al  = req_index[1] & ~req_index[`SBLH_HW_MSB];
  wire        wraps    = req_circ & (req_size == `SBLH_SZ_DBL) & half_al
                         & (idx_end > {1'b0, req_length});
  wire [`SBLH_AW-1:0] first_addr = eff_addr;
  wire [2:0]  first_sz = wraps ? `SBLH_SZ3HW : {1'b0, req_size};

  // overlap of byte ranges, compared on 8-byte line plus lane mask
  wire [7:0]  ld_lanes = wraps ? (`SBLH_LANES_3HW << first_addr[`SBLH_OFS_MSB:0])
                               : (first_sz == {1'b0, `SBLH_SZ_DBL}) ? `SBLH_LANES_DBL
                               : (`SBLH_LANES_WD << first_addr[`SBLH_OFS_MSB:0]);
  // a held store enters the buffer in the very cycle its load is taken,
  // so it must be compared too or a dependent load reads stale memory
  wire                hz_valid = hold_store_ff | sb_valid;
  wire [`SBLH_AW-1:0] hz_addr  = hold_store_ff ? hs_addr_ff : sb_addr;
  wire [7:0]          hz_be    = hold_store_ff ? hs_be_ff : sb_be;
  wire        same_ln  = (hz_addr[`SBLH_AW-1:`SBLH_LN_LSB]
                          == first_addr[`SBLH_AW-1:`SBLH_LN_LSB]);
  wire        hazard   = hz_valid & same_ln & |(hz_be & ld_lanes);

  // ------------------------------------------------------------
  // control
  // ------------------------------------------------------------
  wire idle_st = (state_ff == `SBLH_ST_IDLE);
  assign req_ready = idle_st;
  wire take = req_valid & idle_st;

  always @* begin
    nxt_state     = state_ff;
    nxt_ld_addr   = ld_addr_ff;
    nxt_ld_size   = ld_size_ff;
    nxt_ld_wrap   = ld_wrap_ff;
    nxt_wrap_addr = wrap_addr_ff;
    nxt_rd_phase  = `SBLH_PH_NONE;
    sb_load       = 1'b0;
    sb_clear      = 1'b0;
    mem_req       = 1'b0;
    mem_we        = 1'b0;
    mem_addr      = {`SBLH_AW{1'b0}};
    mem_size      = `SBLH_SZ8B;
    mem_wdata     = {`SBLH_DW{1'b0}};
    mem_be        = 8'h00;
    case (state_ff)
      `SBLH_ST_IDLE: begin
        // buffered store drains on a new store or a bubble
        if (hold_store_ff && (!take || req_store)) begin
          mem_req   = 1'b1;
          mem_we    = 1'b1;
          mem_addr  = hs_addr_ff;
          mem_wdata = hs_data_ff;
          mem_be    = hs_be_ff;
        end else if (hold_store_ff) begin
          sb_load = 1'b1;
        end
        if (sb_valid && (!take || req_store)) begin
          mem_req   = 1'b1;
          mem_we    = 1'b1;
          mem_addr  = sb_addr;
          mem_wdata = sb_data;
          mem_be    = sb_be;
          sb_clear  = 1'b1;
        end
        if (take && !req_store) begin
          nxt_ld_addr   = first_addr;
          nxt_ld_size   = first_sz;
          nxt_ld_wrap   = wraps;
          nxt_wrap_addr = req_base;
          mem_req  = 1'b1;
          mem_addr = first_addr;
          mem_size = first_sz;
          if (hazard) begin
            // access issued then cancelled; store follows next cycle
            nxt_state = `SBLH_ST_STORE;
          end else begin
            nxt_rd_phase = `SBLH_PH_FIRST;
            if (wraps) nxt_state = `SBLH_ST_WRAP;
          end
        end
      end
      `SBLH_ST_STORE: begin
        mem_req   = 1'b1;
        mem_we    = 1'b1;
        mem_addr  = sb_addr;
        mem_wdata = sb_data;
        mem_be    = sb_be;
        sb_clear  = 1'b1;
        nxt_state = `SBLH_ST_REISS;
      end
      `SBLH_ST_REISS: begin
        // reissue keeps the original first-access size, not the wrap size
        mem_req      = 1'b1;
        mem_addr     = ld_addr_ff;
        mem_size     = ld_size_ff;
        nxt_rd_phase = `SBLH_PH_FIRST;
        nxt_state    = ld_wrap_ff ? `SBLH_ST_WRAP : `SBLH_ST_IDLE;
      end
      `SBLH_ST_WRAP: begin
        mem_req      = 1'b1;
        mem_addr     = wrap_addr_ff;
        mem_size     = `SBLH_SZ1HW;
        nxt_rd_phase = `SBLH_PH_WRAP;
        nxt_state    = `SBLH_ST_IDLE;
      end
      default: nxt_state = `SBLH_ST_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // registers and read data capture
  // ------------------------------------------------------------
  // the first part sits at its line offset; shift both parts down before merging
  wire [`SBLH_DW-1:0] part_sh = part_ff >> {ld_addr_ff[`SBLH_OFS_MSB:0], 3'h0};
  wire [`SBLH_DW-1:0] wrap_sh = mem_rdata >> {wrap_addr_ff[`SBLH_OFS_MSB:0], 3'h0};

  // read data is always taken from the access actually made, so a
  // foreign master touching the ram between cancel and reissue is harmless
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff      <= `SBLH_ST_IDLE;
      ld_addr_ff    <= {`SBLH_AW{1'b0}};
      ld_size_ff    <= `SBLH_SZ8B;
      ld_wrap_ff    <= 1'b0;
      wrap_addr_ff  <= {`SBLH_AW{1'b0}};
      rd_phase_ff   <= `SBLH_PH_NONE;
      part_ff       <= {`SBLH_DW{1'b0}};
      rsp_valid_ff  <= 1'b0;
      rsp_data_ff   <= {`SBLH_DW{1'b0}};
      hold_store_ff <= 1'b0;
      hs_addr_ff    <= {`SBLH_AW{1'b0}};
      hs_data_ff    <= {`SBLH_DW{1'b0}};
      hs_be_ff      <= 8'h00;
    end else begin
      state_ff     <= nxt_state;
      ld_addr_ff   <= nxt_ld_addr;
      ld_size_ff   <= nxt_ld_size;
      ld_wrap_ff   <= nxt_ld_wrap;
      wrap_addr_ff <= nxt_wrap_addr;
      rd_phase_ff  <= nxt_rd_phase;
      rsp_valid_ff <= 1'b0;
      // a store waits one slot to see whether a load follows it
      hold_store_ff <= take & req_store;
      if (take && req_store) begin
        hs_addr_ff <= eff_addr;
        hs_data_ff <= req_wdata;
        hs_be_ff   <= req_be;
      end
      if (rd_phase_ff == `SBLH_PH_FIRST) begin
        if (ld_wrap_ff) begin
          part_ff <= mem_rdata;
        end else begin
          rsp_valid_ff <= 1'b1;
          rsp_data_ff  <= mem_rdata;
        end
      end else if (rd_phase_ff == `SBLH_PH_WRAP) begin
        rsp_valid_ff <= 1'b1;
        rsp_data_ff  <= {wrap_sh[`SBLH_HW_BITS-1:0], part_sh[`SBLH_3HW_BITS-1:0]};
      end
    end
  end
endmodule

/* File: rtl/sblh_consts.vh */
// constants for the store buffer / load hazard pipeline block
`ifndef SBLH_CONSTS_VH
`define SBLH_CONSTS_VH
`define SBLH_AW        32
`define SBLH_DW        64
`define SBLH_HW_MSB    0
`define SBLH_SZ_W      2
`define SBLH_SZ_BYTE   2'h0
`define SBLH_SZ_HALF   2'h1
`define SBLH_SZ_WORD   2'h2
`define SBLH_SZ_DBL    2'h3
`define SBLH_SZ3HW     3'h6
`define SBLH_SZ1HW     3'h2
`define SBLH_SZ8B      3'h0
`define SBLH_ST_IDLE   2'h0
`define SBLH_ST_STORE  2'h1
`define SBLH_ST_REISS  2'h2
`define SBLH_ST_WRAP   2'h3
`define SBLH_LN_LSB    3
`define SBLH_OFS_MSB   2
`define SBLH_DBL_BYTES 17'h00008
`define SBLH_LANES_3HW 8'h3F
`define SBLH_LANES_DBL 8'hFF
`define SBLH_LANES_WD  8'h0F
`define SBLH_HW_BITS   16
`define SBLH_3HW_BITS  48
`define SBLH_PH_NONE   2'h0
`define SBLH_PH_FIRST  2'h1
`define SBLH_PH_WRAP   2'h2
`endif

/* File: rtl/sblh_entry.v */
// single store buffer entry register
`include "sblh_consts.vh"
module sblh_entry (
  // clock and reset
  input  wire                  core_clk,
  input  wire                  arst_n,
  // load and clear
  input  wire                  load,
  input  wire                  clear,
  input  wire [`SBLH_AW-1:0]   addr_in,
  input  wire [`SBLH_DW-1:0]   data_in,
  input  wire [7:0]            be_in,
  // held entry
  output reg                   valid_ff,
  output reg  [`SBLH_AW-1:0]   addr_ff,
  output reg  [`SBLH_DW-1:0]   data_ff,
  output reg  [7:0]            be_ff
);
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      valid_ff <= 1'b0;
      addr_ff  <= {`SBLH_AW{1'b0}};
      data_ff  <= {`SBLH_DW{1'b0}};
      be_ff    <= 8'h00;
    end else if (load) begin
      valid_ff <= 1'b1;
      addr_ff  <= addr_in;
      data_ff  <= data_in;
      be_ff    <= be_in;
    end else if (clear) begin
      valid_ff <= 1'b0;
    end
  end
endmodule

/* File: tb/sblh_checker.sv */
// concurrent checks on the load-store pipeline control ports
`include "sblh_consts.vh"
module sblh_chk (
  // watched ports
  input logic        core_clk,
  input logic        arst_n,
  input logic        req_valid,
  input logic        req_ready,
  input logic        req_store,
  input logic [31:0] req_base,
  input logic [15:0] req_index,
  input logic        rsp_valid_ff,
  input logic        mem_req,
  input logic        mem_we,
  input logic [31:0] mem_addr,
  input logic [2:0]  mem_size
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wire tk  = req_valid && req_ready;
  wire rd3 = mem_req && !mem_we && mem_size == `SBLH_SZ3HW;
  logic [31:0] ea_ff, base_ff;
  logic [2:0]  st_cnt_ff, ld_cnt_ff;
  // outstanding stores and loads; a leak shows up as a count that never returns to zero
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_cnt_ff <= 3'h0;
      ld_cnt_ff <= 3'h0;
      ea_ff     <= 32'h0;
      base_ff   <= 32'h0;
    end else begin
      st_cnt_ff <= st_cnt_ff + {2'h0, tk && req_store} - {2'h0, mem_req && mem_we};
      ld_cnt_ff <= ld_cnt_ff + {2'h0, tk && !req_store} - {2'h0, rsp_valid_ff};
      if (tk) begin
        ea_ff   <= req_base + {16'h0, req_index};
        base_ff <= req_base;
      end
    end
  end
  a_one_entry: assert property (st_cnt_ff <= 3'h2) else $error("too many stores held");
  a_defer_store: assert property (tk && req_store ##1 tk && !req_store |-> !mem_we)
    else $error("store written ahead of following load");
  a_store_drain: assert property (!req_valid [*6] |-> st_cnt_ff == 3'h0)
    else $error("store not drained on idle pipeline");
  a_reissue_size: assert property (rd3 ##1 (mem_req && mem_we) |=> rd3)
    else $error("cancelled access reissued with wrong size");
  a_load_answer: assert property (tk && !req_store |-> ##[2:6] rsp_valid_ff)
    else $error("load not answered in time");
  a_no_spurious: assert property (rsp_valid_ff |-> ld_cnt_ff != 3'h0)
    else $error("load answer without a load");
  a_circ_addr: assert property (rd3 |-> mem_addr ==
    (tk ? req_base + {16'h0, req_index} : ea_ff))
    else $error("circular address not base plus index");
  a_wrap_split: assert property (rd3 && tk |-> ##[1:3] (mem_req && !mem_we
    && mem_size == `SBLH_SZ1HW && mem_addr == base_ff)) else $error("wrapped half missing");
endmodule
bind sblh_lsu sblh_chk i_sblh_chk (.core_clk, .arst_n, .req_valid, .req_ready, .req_store,
  .req_base, .req_index, .rsp_valid_ff, .mem_req, .mem_we, .mem_addr, .mem_size);

/* File: tb/sblh_spm.sv */
// scratchpad partner model with a second bus master write port
module sblh_spm (
  // scratchpad port
  input  logic        core_clk,
  input  logic        mem_req,
  input  logic        mem_we,
  input  logic [31:0] mem_addr,
  input  logic [63:0] mem_wdata,
  input  logic [7:0]  mem_be,
  output logic [63:0] mem_rdata,
  // other master
  input  logic        other_we,
  input  logic [3:0]  other_line,
  input  logic [63:0] other_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] line_mem [16];
  initial mem_rdata = 64'h0;
  always @(posedge core_clk) begin
    // outside the valid cycle the output toggles so stale data never looks right
    if (mem_req && !mem_we) mem_rdata <= line_mem[mem_addr[6:3]];
    else mem_rdata <= ~mem_rdata;
    if (mem_req && mem_we)
      for (int i = 0; i < 8; i++)
        if (mem_be[i]) line_mem[mem_addr[6:3]][8*i +: 8] <= mem_wdata[8*i +: 8];
    if (other_we) line_mem[other_line] <= other_data;
  end
endmodule

/* File: tb/test_store_buffer_load_hazard.sv */
// self-checking bench for the store buffer and load hazard block
`include "sblh_consts.vh"
module test_store_buffer_load_hazard;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, arst_n, req_valid, req_ready, req_store, req_circ, other_we;
  logic rsp_valid_ff, mem_req, mem_we;
  logic [31:0] req_addr, req_base, mem_addr;
  logic [15:0] req_index, req_length;
  logic [1:0]  req_size;
  logic [2:0]  mem_size;
  logic [7:0]  req_be, mem_be;
  logic [63:0] req_wdata, rsp_data_ff, mem_wdata, mem_rdata, other_data;
  int n_errors = 0;
  int samples_checked = 0;
  // rows: store address, data, lanes, then load address and its answer
  logic [31:0] r_st [4] = '{32'h08, 32'h08, 32'h10, 32'h10};
  logic [63:0] r_d [4] = '{64'h1122334455667788, 64'hAAAAAAAAAAAAAAAA,
                           64'h0123456789ABCDEF, 64'hFFFFFFFF00000000};
  logic [7:0]  r_be [4] = '{8'hFF, 8'h0F, 8'hFF, 8'hF0};
  logic [31:0] r_ld [4] = '{32'h08, 32'h08, 32'h08, 32'h10};
  logic [63:0] r_exp [4] = '{64'h1122334455667788, 64'h11223344AAAAAAAA,
                             64'h11223344AAAAAAAA, 64'hFFFFFFFF89ABCDEF};
  sblh_lsu i_sblh_lsu (.core_clk, .arst_n, .req_valid, .req_ready, .req_store, .req_circ,
    .req_addr, .req_base, .req_index, .req_length, .req_size, .req_wdata, .req_be,
    .rsp_valid_ff, .rsp_data_ff, .mem_req, .mem_we, .mem_addr, .mem_size, .mem_wdata,
    .mem_be, .mem_rdata);
  sblh_spm i_sblh_spm (.core_clk, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_be,
    .mem_rdata, .other_we, .other_line(4'hF), .other_data);
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // holds the request until an edge that sees ready high
  task op(input logic st, input logic circ, input logic [31:0] a, input logic [63:0] d,
          input logic [7:0] be);
    int k;
    req_valid = 1'b1; req_store = st; req_circ = circ;
    req_addr = a; req_wdata = d; req_be = be;
    k = 0;
    while (req_ready !== 1'b1 && k < 50) begin @(posedge core_clk); #1; k++; end
    if (k == 50) begin n_errors++; end_of_test; end
    @(posedge core_clk); #1;
  endtask
  task rsp(input logic [63:0] exp);
    int k;
    k = 0;
    while (rsp_valid_ff !== 1'b1 && k < 20) begin @(posedge core_clk); #1; k++; end
    if (k == 20) begin n_errors++; end_of_test; end
    chk(rsp_data_ff, exp);
  endtask
  initial begin
    arst_n = 1'b0; req_valid = 1'b0; req_store = 1'b0; req_circ = 1'b0; req_addr = 32'h0;
    req_base = 32'h40; req_index = 16'h12; req_length = 16'h18; req_size = `SBLH_SZ_DBL;
    req_wdata = 64'h0; req_be = 8'h0; other_we = 1'b0; other_data = 64'h5A5A5A5A5A5A5A5A;
    repeat (16) @(posedge core_clk);
    #1 arst_n = 1'b1;
    chk({62'h0, req_ready, rsp_valid_ff | mem_req}, 64'h2);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      op(1'b1, 1'b0, r_st[i], r_d[i], r_be[i]);
      op(1'b0, 1'b0, r_ld[i], 64'h0, 8'h0);
      req_valid = 1'b0;
      rsp(r_exp[i]);
      $display("test row %0d done", i);
    end
    op(1'b1, 1'b0, 32'h40, 64'h000000000000CAFE, 8'hFF);
    op(1'b1, 1'b0, 32'h50, 64'h8877665544332211, 8'hFF);
    op(1'b1, 1'b0, 32'h50, 64'hBEEF000000000000, 8'hC0);
    op(1'b0, 1'b1, 32'h0, 64'h0, 8'h0);
    req_valid = 1'b0;
    other_we = 1'b1;
    @(posedge core_clk); #1 other_we = 1'b0;
    rsp(64'hCAFEBEEF66554433);
    $display("test wrap hazard done");
    op(1'b0, 1'b1, 32'h0, 64'h0, 8'h0);
    req_valid = 1'b0;
    rsp(64'hCAFEBEEF66554433);
    $display("test wrap plain done");
    // reset while a hazard is being resolved: the pending store is dropped
    op(1'b1, 1'b0, 32'h20, 64'h0, 8'hFF);
    op(1'b0, 1'b0, 32'h20, 64'h0, 8'h0);
    req_valid = 1'b0;
    arst_n = 1'b0;
    #1 chk({62'h0, req_ready, rsp_valid_ff | mem_req}, 64'h2);
    @(posedge core_clk); #1 arst_n = 1'b1;
    op(1'b0, 1'b0, 32'h08, 64'h0, 8'h0);
    req_valid = 1'b0;
    rsp(64'h11223344AAAAAAAA);
    $display("test reset mid-run done");
    repeat (8) @(posedge core_clk);
    end_of_test;
  end
endmodule
